/* File: bflc_pkg.sv */
// Package: boot flash lock control constants, types and register map
package bflc_pkg;

    // Register byte addresses on the Wishbone bus
    localparam logic [3:0] BFLC_SPC_OFFS    = 4'h0;  // self_program_control_status
    localparam logic [3:0] BFLC_LOCK_OFFS   = 4'h4;  // lock fields, fuse view
    localparam logic [3:0] BFLC_IRQST_OFFS  = 4'h8;  // sticky event status
    localparam logic [3:0] BFLC_IRQMSK_OFFS = 4'hC;  // event mask

    // Control register bit positions
    localparam int BFLC_IE_BIT   = 7;
    localparam int BFLC_BUSY_BIT = 6;
    localparam int BFLC_RES_BIT  = 5;
    localparam int BFLC_RRE_BIT  = 4;
    localparam int BFLC_LBS_BIT  = 3;
    localparam int BFLC_PWR_BIT  = 2;
    localparam int BFLC_PER_BIT  = 1;
    localparam int BFLC_SPE_BIT  = 0;

    // Accepted low five-bit command codes
    localparam logic [4:0] BFLC_CMD_RRE   = 5'h11;
    localparam logic [4:0] BFLC_CMD_LBS   = 5'h09;
    localparam logic [4:0] BFLC_CMD_PWR   = 5'h05;
    localparam logic [4:0] BFLC_CMD_PER   = 5'h03;
    localparam logic [4:0] BFLC_CMD_LOAD  = 5'h01;

    // Status event bit positions
    localparam int BFLC_EV_WR_DENY = 0;
    localparam int BFLC_EV_RD_DENY = 1;
    localparam int BFLC_EV_DONE    = 2;
    localparam int BFLC_EV_IGNORED = 3;
    localparam int BFLC_EV_W       = 4;

    // Reset values
    localparam logic [7:0] BFLC_SPC_RST  = 8'h00;
    localparam logic [3:0] BFLC_LOCK_RST = 4'hF;  // all unprogrammed
    localparam logic [3:0] BFLC_EV_RST   = 4'h0;

    // Arming window after a control write
    localparam int         BFLC_ARM_CYCLES = 4;
    localparam logic [2:0] BFLC_ARM_LOAD   = 3'h4;

    // Address of the first fetch with the boot fuse unprogrammed
    localparam logic [15:0] BFLC_APP_RESET_ADDR = 16'h0000;

    // Flash operation handshake state
    typedef enum logic [1:0] {
        BFLC_IDLE = 2'b00,
        BFLC_BUSY = 2'b01,
        BFLC_DONE = 2'b11
    } bflc_state_t;

    // Core program-memory request
    typedef struct packed {
        logic        spm_valid;
        logic        lpm_valid;
        logic [15:0] pc;      // executing instruction address
        logic [15:0] target;  // Z pointer target
        logic [7:0]  r0;      // low data register
    } bflc_core_req_t;

    // Decision back to the core
    typedef struct packed {
        logic        spm_go;
        logic [2:0]  spm_cmd;  // 0 load,1 erase,2 write,3 lock,4 rww enable
        logic        lpm_ok;
        logic        lpm_deny;
        logic        irq_block;
    } bflc_core_rsp_t;

endpackage : bflc_pkg

/* File: bflc_lock_store.sv */
// Boot lock field store: set-only by software, restored by chip erase
`timescale 1ns/10ps
`default_nettype none
module bflc_lock_store #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             chip_erase_i,
    input  wire logic             ext_prog_i,
    input  wire logic [WIDTH-1:0] ext_data_i,
    input  wire logic             sw_set_i,
    input  wire logic [WIDTH-1:0] sw_data_i,
    output logic      [WIDTH-1:0] lock_o
);
    initial begin
        if (WIDTH != 4) $error("bflc_lock_store needs WIDTH 4");
    end

    typedef struct packed {
        logic [WIDTH-1:0] lock;
    } bflc_ls_t;

    bflc_ls_t st_r;
    bflc_ls_t st_nxt;

    // Programming only clears bits, so protection can only tighten
    always_comb begin
        st_nxt = st_r;
        if (chip_erase_i) begin
            st_nxt.lock = bflc_pkg::BFLC_LOCK_RST;
        end else begin
            if (ext_prog_i) begin
                st_nxt.lock = st_nxt.lock & ext_data_i;
            end
            if (sw_set_i) begin
                st_nxt.lock = st_nxt.lock & sw_data_i;
            end
        end
    end

    // Survives the system reset: non-volatile in the real part
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign lock_o = st_r.lock;
endmodule // bflc_lock_store
`default_nettype wire

/* File: bflc_top.sv */
// Boot flash lock control: access checks, control register, ready irq
//
// How it works
// - Locks set by software/programmer, cleared by erase
// - General write lock never blocks store
// - General read/write lock never blocks load/store
// - Application modes 2,3 refuse application writes
// - Application high bit zero blocks boot reads
// - Application high zero, boot vectors: hold irqs
// - Boot modes 2,3 refuse boot area writes
// - Boot high bit zero blocks application reads
// - Boot high zero, application vectors: hold irqs
// - Bit value one means unprogrammed
// - Reset fetch address chosen by boot fuse
// - Core can never alter fuses
// - Control register bit layout
// - Ready irq while enable set and idle
// - Stores from application area are ignored
// - Busy set on rww op, cleared later
// - Self-program enable armed for four cycles
// - Lock-set stores program locks from r0
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bflc_top #(
    parameter logic [15:0] BOOT_START = 16'h1800,
    parameter logic [15:0] NO_READ_WHILE_WRITE_AREA_START = 16'h1800,
    parameter int          ADDR_W     = 16
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone classic slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [3:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    output logic                         err_o,
    // Core side
    input  wire bflc_pkg::bflc_core_req_t core_req_i,
    output bflc_pkg::bflc_core_rsp_t      core_rsp_o,
    input  wire logic                    gie_i,
    input  wire logic                    ivec_in_boot_i,
    input  wire logic                    page_load_i,
    input  wire logic                    flash_done_i,
    // Programmer side, fuses, reset vector and interrupt outputs
    input  wire logic                    chip_erase_i,
    input  wire logic                    ext_lock_wr_i,
    input  wire logic [3:0]              ext_lock_data_i,
    input  wire logic                    boot_reset_fuse_i,
    output logic      [15:0]             reset_vector_o,
    output logic                         spm_ready_irq_o,
    output logic                         irq_o
);
    initial begin
        if (ADDR_W != 16) $error("bflc_top supports 16-bit addresses only");
        if (BOOT_START == 16'h0000) $error("boot area cannot start at zero");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = (a >= BOOT_START);
    endfunction

    function automatic logic in_rww(input logic [15:0] a);
        in_rww = (a < NO_READ_WHILE_WRITE_AREA_START);
    endfunction

    // Modes 2 and 3 have low bit 0 and forbid writes
    function automatic logic wr_locked(input logic [1:0] f);
        wr_locked = ~f[0];
    endfunction

    // Modes 3 and 4 have high bit 0 and forbid cross reads
    function automatic logic rd_locked(input logic [1:0] f);
        rd_locked = ~f[1];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]              spc;
        logic [2:0]              arm_cnt;
        bflc_pkg::bflc_state_t   fsm;
        logic                    op_rww;
        logic [3:0]              ev_st;
        logic [3:0]              ev_msk;
        logic [31:0]             dat;
        logic                    ack;
        logic                    err;
        logic                    lock_set;
        logic [3:0]              lock_val;
        bflc_pkg::bflc_core_rsp_t rsp;
        logic [15:0]             rvec;
        logic                    ready_irq;
        logic                    irq;
    } bflc_top_st_t;

    bflc_top_st_t st_r;
    bflc_top_st_t st_nxt;
    logic [3:0]   lock_w;
    logic [1:0]   app_f;
    logic [1:0]   boot_f;

    assign app_f  = lock_w[1:0];
    assign boot_f = lock_w[3:2];

    // Only the core path and the programmer reach the locks; no fuse path
    bflc_lock_store #(
        .WIDTH (4)
    ) u_locks (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .chip_erase_i (chip_erase_i),
        .ext_prog_i   (ext_lock_wr_i),
        .ext_data_i   (ext_lock_data_i),
        .sw_set_i     (st_r.lock_set),
        .sw_data_i    (st_r.lock_val),
        .lock_o       (lock_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    logic        bus_req;
    logic        wr_spc;
    logic [4:0]  cmd;
    logic        pc_boot;
    logic        tgt_boot;
    logic        spm_ok;
    logic        wr_deny;
    logic [3:0]  ev_set;
    logic        armed;

    always_comb begin
        st_nxt          = st_r;
        ev_set          = 4'h0;
        st_nxt.ack      = 1'b0;
        st_nxt.err      = 1'b0;
        st_nxt.lock_set = 1'b0;
        st_nxt.rsp      = '0;
        bus_req  = cyc_i && stb_i && !st_r.ack && !st_r.err;
        wr_spc   = bus_req && we_i && sel_i[0] && (adr_i == bflc_pkg::BFLC_SPC_OFFS);
        cmd      = dat_i[4:0];
        pc_boot  = in_boot(core_req_i.pc);
        tgt_boot = in_boot(core_req_i.target);
        armed    = (st_r.arm_cnt != 3'h0);
        wr_deny  = tgt_boot ? wr_locked(boot_f) : wr_locked(app_f);
        // General lock modes are not consulted at all here
        spm_ok   = armed && pc_boot;

        // Reset vector tracks the fuse; the core has no path to change it
        st_nxt.rvec = boot_reset_fuse_i ? bflc_pkg::BFLC_APP_RESET_ADDR
                                        : BOOT_START;

        // Arming countdown
        if (armed && st_r.fsm == bflc_pkg::BFLC_IDLE) begin
            st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
            if (st_r.arm_cnt == 3'h1) begin
                st_nxt.spc[4:0] = 5'h00;
            end
        end

        // Page load clears busy; placed first so a same-cycle op start wins
        if (page_load_i) begin
            st_nxt.spc[bflc_pkg::BFLC_BUSY_BIT] = 1'b0;
        end

        // Store instruction
        if (core_req_i.spm_valid) begin
            if (!spm_ok) begin
                ev_set[bflc_pkg::BFLC_EV_IGNORED] = 1'b1;
            end else begin
                st_nxt.arm_cnt = 3'h0;
                st_nxt.spc[4:0] = 5'h00;
                case (st_r.spc[4:0])
                    bflc_pkg::BFLC_CMD_LBS: begin
                        st_nxt.lock_set   = 1'b1;
                        st_nxt.lock_val   = core_req_i.r0[5:2];
                        st_nxt.rsp.spm_go  = 1'b1;
                        st_nxt.rsp.spm_cmd = 3'h3;
                    end
                    bflc_pkg::BFLC_CMD_PER,
                    bflc_pkg::BFLC_CMD_PWR: begin
                        if (wr_deny) begin
                            ev_set[bflc_pkg::BFLC_EV_WR_DENY] = 1'b1;
                        end else begin
                            st_nxt.rsp.spm_go  = 1'b1;
                            st_nxt.rsp.spm_cmd = st_r.spc[1] ? 3'h1 : 3'h2;
                            st_nxt.fsm         = bflc_pkg::BFLC_BUSY;
                            st_nxt.spc[bflc_pkg::BFLC_SPE_BIT] = 1'b1;
                            st_nxt.spc[2:1]    = st_r.spc[2:1];
                            st_nxt.op_rww      = in_rww(core_req_i.target);
                            if (in_rww(core_req_i.target)) begin
                                st_nxt.spc[bflc_pkg::BFLC_BUSY_BIT] = 1'b1;
                            end
                        end
                    end
                    bflc_pkg::BFLC_CMD_RRE: begin
                        st_nxt.spc[bflc_pkg::BFLC_BUSY_BIT] = 1'b0;
                        st_nxt.rsp.spm_go  = 1'b1;
                        st_nxt.rsp.spm_cmd = 3'h4;
                    end
                    default: begin
                        st_nxt.rsp.spm_go  = 1'b1;
                        st_nxt.rsp.spm_cmd = 3'h0;
                    end
                endcase
            end
        end

        // Flash operation completion
        case (st_r.fsm)
            bflc_pkg::BFLC_IDLE: begin
            end
            bflc_pkg::BFLC_BUSY: begin
                if (flash_done_i) begin
                    st_nxt.fsm = bflc_pkg::BFLC_DONE;
                end
            end
            bflc_pkg::BFLC_DONE: begin
                st_nxt.fsm      = bflc_pkg::BFLC_IDLE;
                st_nxt.spc[4:0] = 5'h00;
                ev_set[bflc_pkg::BFLC_EV_DONE] = 1'b1;
            end
            default: begin
                st_nxt.fsm = bflc_pkg::BFLC_IDLE;
            end
        endcase

        // Load instruction: cross-area reads per the other field
        if (core_req_i.lpm_valid) begin
            if ((pc_boot && !tgt_boot && rd_locked(app_f)) ||
                (!pc_boot && tgt_boot && rd_locked(boot_f))) begin
                st_nxt.rsp.lpm_deny = 1'b1;
                ev_set[bflc_pkg::BFLC_EV_RD_DENY] = 1'b1;
            end else begin
                st_nxt.rsp.lpm_ok = 1'b1;
            end
        end

        // Interrupt hold-off
        st_nxt.rsp.irq_block = (!pc_boot && ivec_in_boot_i && rd_locked(app_f))
                            || (pc_boot && !ivec_in_boot_i && rd_locked(boot_f));

        ////////////////////////////////////////////////////////////////////
        // Bus slave
        if (bus_req) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = 32'h0000_0000;
            case (adr_i)
                bflc_pkg::BFLC_SPC_OFFS: begin
                    st_nxt.dat[7:0] = st_r.spc;
                end
                bflc_pkg::BFLC_LOCK_OFFS: begin
                    st_nxt.dat[3:0] = lock_w;
                    st_nxt.dat[8]   = boot_reset_fuse_i;
                end
                bflc_pkg::BFLC_IRQST_OFFS: begin
                    st_nxt.dat[3:0] = st_r.ev_st;
                    if (we_i && sel_i[0]) begin
                        st_nxt.ev_st = st_r.ev_st & ~dat_i[3:0];
                    end
                end
                bflc_pkg::BFLC_IRQMSK_OFFS: begin
                    st_nxt.dat[3:0] = st_r.ev_msk;
                    if (we_i && sel_i[0]) begin
                        st_nxt.ev_msk = dat_i[3:0];
                    end
                end
                default: begin
                    st_nxt.ack = 1'b0;
                    st_nxt.err = 1'b1;
                end
            endcase
        end

        // Control write: bit 7 always, low bits only for legal codes when idle
        if (wr_spc) begin
            st_nxt.spc[bflc_pkg::BFLC_IE_BIT] = dat_i[bflc_pkg::BFLC_IE_BIT];
            if (st_r.fsm == bflc_pkg::BFLC_IDLE &&
                (cmd == bflc_pkg::BFLC_CMD_RRE || cmd == bflc_pkg::BFLC_CMD_LBS ||
                 cmd == bflc_pkg::BFLC_CMD_PWR || cmd == bflc_pkg::BFLC_CMD_PER ||
                 cmd == bflc_pkg::BFLC_CMD_LOAD)) begin
                st_nxt.spc[4:0] = cmd;
                st_nxt.arm_cnt  = bflc_pkg::BFLC_ARM_LOAD;
            end
        end
        st_nxt.spc[bflc_pkg::BFLC_RES_BIT] = 1'b0;

        // Events: set wins over a same-cycle clear
        st_nxt.ev_st = st_nxt.ev_st | ev_set;
        st_nxt.irq   = |(st_nxt.ev_st & st_nxt.ev_msk);

        st_nxt.ready_irq = st_nxt.spc[bflc_pkg::BFLC_IE_BIT] && gie_i
                        && !st_nxt.spc[bflc_pkg::BFLC_SPE_BIT];

        if (rst_i) begin
            st_nxt        = '0;
            st_nxt.spc    = bflc_pkg::BFLC_SPC_RST;
            st_nxt.ev_st  = bflc_pkg::BFLC_EV_RST;
            st_nxt.fsm    = bflc_pkg::BFLC_IDLE;
            st_nxt.rvec   = boot_reset_fuse_i ? bflc_pkg::BFLC_APP_RESET_ADDR
                                              : BOOT_START;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state register
    assign dat_o           = st_r.dat;
    assign ack_o           = st_r.ack;
    assign err_o           = st_r.err;
    assign core_rsp_o      = st_r.rsp;
    assign reset_vector_o  = st_r.rvec;
    assign spm_ready_irq_o = st_r.ready_irq;
    assign irq_o           = st_r.irq;
endmodule // bflc_top
`default_nettype wire

/* File: bflc_monitor.sv */
// Checker: bus answer, core decision and vector relations of the lock block
`timescale 1ns/10ps
`default_nettype none
module bflc_monitor #(
    parameter logic [15:0] BOOT_START = 16'h1800
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic [3:0]               adr_i,
    input  wire logic                     ack_o,
    input  wire logic                     err_o,
    input  wire bflc_pkg::bflc_core_req_t core_req_i,
    input  wire bflc_pkg::bflc_core_rsp_t core_rsp_o,
    input  wire logic                     gie_i,
    input  wire logic                     ivec_in_boot_i,
    input  wire logic                     boot_reset_fuse_i,
    input  wire logic [15:0]              reset_vector_o,
    input  wire logic                     spm_ready_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        cyc_i && stb_i && !ack_o && !err_o;
    endsequence
    sequence s_same_area;
        (ivec_in_boot_i && core_req_i.pc >= BOOT_START) ||
        (!ivec_in_boot_i && core_req_i.pc < BOOT_START);
    endsequence
    property p_ack;
        s_take ##0 (adr_i[1:0] == 2'h0) |=> ack_o && !err_o;
    endproperty
    property p_err;
        s_take ##0 (adr_i[1:0] != 2'h0) |=> err_o && !ack_o;
    endproperty
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    property p_vector;
        1'b1 |=> reset_vector_o == ($past(boot_reset_fuse_i) ? 16'h0000 : BOOT_START);
    endproperty
    property p_app_ignored;
        core_req_i.spm_valid && core_req_i.pc < BOOT_START |=> !core_rsp_o.spm_go;
    endproperty
    property p_go_cause;
        core_rsp_o.spm_go |-> $past(core_req_i.spm_valid) && $past(core_req_i.pc) >= BOOT_START;
    endproperty
    property p_load_answer;
        core_req_i.lpm_valid |=> core_rsp_o.lpm_ok != core_rsp_o.lpm_deny;
    endproperty
    property p_no_block;
        s_same_area |=> !core_rsp_o.irq_block;
    endproperty
    property p_ready_gie;
        spm_ready_irq_o |-> $past(gie_i);
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_err: assert property (p_err) else $error("err missing");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_vector: assert property (p_vector) else $error("reset vector wrong");
    a_app_ignored: assert property (p_app_ignored) else $error("app store ran");
    a_go_cause: assert property (p_go_cause) else $error("store go uncaused");
    a_load_answer: assert property (p_load_answer) else $error("load answer");
    a_no_block: assert property (p_no_block) else $error("irq held wrongly");
    a_ready_gie: assert property (p_ready_gie) else $error("ready irq w/o gie");
endmodule // bflc_monitor
bind bflc_top bflc_monitor #(.BOOT_START(BOOT_START)) mon_u (
    .clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .ack_o, .err_o, .core_req_i, .core_rsp_o,
    .gie_i, .ivec_in_boot_i, .boot_reset_fuse_i, .reset_vector_o, .spm_ready_irq_o
);
`default_nettype wire

/* File: bflc_core_model.sv */
// Core model: issues store and load requests, ends erase and write later
`timescale 1ns/10ps
`default_nettype none
module bflc_core_model (
    input  wire logic                     clk_i,
    input  wire bflc_pkg::bflc_core_rsp_t core_rsp_o,
    output bflc_pkg::bflc_core_req_t      core_req_o,
    output logic                          flash_done_o
);
    int done_dly = 3;  // Flash busy span, bench picks short or long
    int cnt      = 0;
    initial begin
        core_req_o   = '0;
        flash_done_o = 1'b0;
    end
    always @(posedge clk_i) begin
        flash_done_o <= (cnt == 1);
        if (core_rsp_o.spm_go && core_rsp_o.spm_cmd inside {3'h1, 3'h2}) begin
            cnt <= done_dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Store (st=1) or load; r0 carries lock data for a lock-set store
    task automatic req(input logic st, input logic [15:0] pc, tgt, input logic [7:0] r0,
                       output bflc_pkg::bflc_core_rsp_t rsp);
        @(posedge clk_i);
        core_req_o <= {st, !st, pc, tgt, r0};
        @(posedge clk_i);
        // Pointer and data no longer qualified: show garbage, pc stays
        core_req_o <= {2'b00, pc, ~tgt, ~r0};
        @(negedge clk_i);
        rsp = core_rsp_o;
    endtask
endmodule // bflc_core_model
`default_nettype wire

/* File: tb_top.sv */
// Bench: register bus and core request sequences for the lock control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0, ext_lock_data_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic        gie_i = 1'b0, ivec_in_boot_i = 1'b0, page_load_i = 1'b0;
    logic        chip_erase_i = 1'b0, ext_lock_wr_i = 1'b0, boot_reset_fuse_i = 1'b1;
    logic        ack_o, err_o, spm_ready_irq_o, irq_o, flash_done_i, e, a;
    logic [15:0] reset_vector_o;
    bflc_pkg::bflc_core_req_t core_req_i;
    bflc_pkg::bflc_core_rsp_t core_rsp_o, r;
    int          fail_count = 0, checked = 0;
    bflc_top dut_u (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .err_o, .core_req_i, .core_rsp_o, .gie_i, .ivec_in_boot_i, .page_load_i,
        .flash_done_i, .chip_erase_i, .ext_lock_wr_i, .ext_lock_data_i, .boot_reset_fuse_i,
        .reset_vector_o, .spm_ready_irq_o, .irq_o
    );
    bflc_core_model core_u (
        .clk_i, .core_rsp_o, .core_req_o(core_req_i), .flash_done_o(flash_done_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, ad, 4'hF, d};
        // Answer taken at the edge that sees it; only the watchdog ends a hang
        do @(posedge clk_i); while (!(ack_o | err_o));
        q = dat_o;
        e = err_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #(4 * 5000);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        chip_erase_i <= 1'b1;
        @(posedge clk_i);
        chip_erase_i <= 1'b0;
        repeat (11) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 4'h0, 0); chk(q, 32'h0);
        wb(0, 4'h2, 0); chkb(e, 1'b1);
        // Invalid code: only the enable bit lands, busy and reserved stay 0
        wb(1, 4'h0, 32'hFF); wb(0, 4'h0, 0); chk(q, 32'h80);
        @(posedge clk_i); gie_i <= 1'b1;
        settle(); chkb(spm_ready_irq_o, 1'b1);
        wb(1, 4'h0, 32'h85); settle(); chkb(spm_ready_irq_o, 1'b0);
        repeat (4) @(posedge clk_i);
        wb(0, 4'h0, 0); chk(q, 32'h80);
        core_u.req(1, 16'h1800, 16'h0100, 8'h00, r); chkb(r.spm_go, 1'b0);
        wb(1, 4'h0, 32'h05); core_u.req(1, 16'h0100, 16'h0100, 8'h00, r);
        chkb(r.spm_go, 1'b0);
        wb(0, 4'h8, 0); chkb(q[3], 1'b1);
        wb(1, 4'hC, 0); settle(); a = irq_o;
        wb(1, 4'hC, 32'h08); settle(); chkb(a ^ irq_o, 1'b1);
        wb(1, 4'h8, 32'h08); wb(0, 4'h8, 0); chkb(q[3], 1'b0);
        settle(); chkb(irq_o, 1'b0);
        // Boot field to mode 2, application field untouched
        wb(1, 4'h0, 32'h09); core_u.req(1, 16'h1800, 16'h0, 8'h2C, r);
        chk({r.spm_go, r.spm_cmd}, 32'h0B);
        settle();
        wb(1, 4'h0, 32'h03); core_u.req(1, 16'h1800, 16'h1900, 8'h00, r);
        chkb(r.spm_go, 1'b0);
        wb(0, 4'h8, 0); chkb(q[0], 1'b1);
        core_u.done_dly = 20;
        wb(1, 4'h0, 32'h03); core_u.req(1, 16'h1800, 16'h0100, 8'h00, r);
        chk({r.spm_go, r.spm_cmd}, 32'h09);
        wb(0, 4'h0, 0); chk(q & 32'h41, 32'h41);
        repeat (24) @(posedge clk_i);
        wb(0, 4'h0, 0); chk(q & 32'h41, 32'h40);
        @(posedge clk_i); page_load_i <= 1'b1;
        @(posedge clk_i); page_load_i <= 1'b0;
        wb(0, 4'h0, 0); chkb(q[6], 1'b0);
        wb(1, 4'h0, 32'h11); core_u.req(1, 16'h1800, 16'h0, 8'h00, r);
        chk({r.spm_go, r.spm_cmd}, 32'h0C);
        wb(1, 4'h0, 32'h01); core_u.req(1, 16'h1800, 16'h0, 8'h00, r);
        chk({r.spm_go, r.spm_cmd}, 32'h08);
        core_u.done_dly = 1;
        // Application field to mode 3, boot field stays mode 2
        wb(1, 4'h0, 32'h09); core_u.req(1, 16'h1800, 16'h0, 8'h20, r);
        settle();
        wb(1, 4'h0, 32'h05); core_u.req(1, 16'h1800, 16'h0200, 8'h00, r);
        chkb(r.spm_go, 1'b0);
        core_u.req(0, 16'h1800, 16'h0100, 8'h00, r); chkb(r.lpm_deny, 1'b1);
        wb(0, 4'h8, 0); chk(q, 32'h7);
        @(posedge clk_i); ivec_in_boot_i <= 1'b1;
        core_u.req(0, 16'h0100, 16'h1900, 8'h00, r); chkb(r.lpm_ok, 1'b1);
        settle(); chkb(core_rsp_o.irq_block, 1'b1);
        // Programmer moves boot field to mode 3
        @(posedge clk_i); {ext_lock_wr_i, ext_lock_data_i} <= 5'h17;
        @(posedge clk_i); ext_lock_wr_i <= 1'b0;
        core_u.req(0, 16'h0100, 16'h1900, 8'h00, r); chkb(r.lpm_deny, 1'b1);
        @(posedge clk_i); ivec_in_boot_i <= 1'b0;
        core_u.req(0, 16'h1800, 16'h1900, 8'h00, r); chkb(r.lpm_ok, 1'b1);
        settle(); chkb(core_rsp_o.irq_block, 1'b1);
        wb(1, 4'h4, 0); settle(); chk(reset_vector_o, 32'h0000);
        @(posedge clk_i); boot_reset_fuse_i <= 1'b0;
        settle(); chk(reset_vector_o, 32'h1800);
        @(posedge clk_i); chip_erase_i <= 1'b1;
        @(posedge clk_i); chip_erase_i <= 1'b0;
        core_u.req(0, 16'h1800, 16'h0100, 8'h00, r); chkb(r.lpm_ok, 1'b1);
        settle(); chkb(core_rsp_o.irq_block, 1'b0);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
